// file: core/adc_port_pkg.sv
/*
 * Constants shared by the converter output port: word width, pin roles on
 * the data bus, buffer size and the internal serial clock timing.
 * Assumes a 25 MHz system clock; all other modules import this package.
 */
package adc_port_pkg;

    // ------------------------------------------------------------
    // Word and pin layout
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int MSB_BIT = DATA_W - 1;
    localparam int LOW_PINS = 4;          // Pins 0..3 always drive.
    localparam int SCLK_SEL_BIT = 4;      // Clock source select in serial mode.
    localparam int SER_IN_HI = 7;         // Pins 4..7 are inputs in serial mode.
    localparam int SDOUT_BIT = 8;         // Serial data leaves on this pin.
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hf;

    // ------------------------------------------------------------
    // Buffer and timing
    // ------------------------------------------------------------
    localparam int BUF_DEPTH = 2;
    localparam int CLK_PERIOD_NS = 40;
    localparam int INT_SCLK_PERIOD_NS = 80;
    // Longest half period, rounded down, never below one cycle.
    localparam int SCLK_HALF_CYC = ((INT_SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS) < 1 ? 1 :
                                   ((INT_SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS);
    localparam int DIV_W = 4;

    typedef logic [DATA_W-1:0] word_t;

    // Two's complement is straight binary with the top bit inverted.
    function automatic word_t apply_coding(input word_t raw, input logic straight);
        word_t mask;
        mask = '0;
        mask[MSB_BIT] = ~straight;
        return raw ^ mask;
    endfunction

endpackage

// file: core/adc_output_port.sv
/*
 * Output port of the converter: takes result words from the conversion core,
 * buffers two of them, and delivers them on the parallel data bus or, in
 * serial mode, shifted out MSB first on a reused data pin.
 * Assumes the result stream comes from logic on ref_clk; every pin input
 * arrives from outside and is synchronised before use.
 */
// Function
// - Coding select high gives straight binary; low inverts the MSB for two's complement.
// - Port type select low delivers results on the parallel data bus.
// - Port type select high enters serial mode, reusing some data pins.
// - Data pins 0 to 3 are driven outputs in every mode.
// - Pin 4 carries result bit 4 in parallel, clock source select in serial.
// - Serial with select low: device makes the serial clock and drives it out.
// - Serial with select high: host supplies the clock, device shifts data on it.
`timescale 1ns/1ps
`default_nettype none

module adc_output_port (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire adc_port_pkg::word_t result_data,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic output_coding_select,
    input wire logic port_type_select,
    input wire logic read_strobe,
    output logic word_ready,
    input wire adc_port_pkg::word_t data_in,
    output adc_port_pkg::word_t data_out,
    output adc_port_pkg::word_t data_oe_n,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe_n
);
    import adc_port_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Two flops per pin; logic reads the second stage and, for clock and strobe edges, a third. The
    // assumption lets the selects be sampled this way without a word lock.
    logic [4:0] sync1, sync2;
    logic sclk_d, strobe_d;
    logic coding_s, serial_s, ext_s, strobe_s, sclk_s;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            sclk_d <= 1'b0;
            strobe_d <= 1'b0;
        end else begin
            sync1 <= {sclk_in, read_strobe, data_in[SCLK_SEL_BIT], port_type_select, output_coding_select};
            sync2 <= sync1;
            sclk_d <= sync2[4];
            strobe_d <= sync2[3];
        end
    end

    assign coding_s = sync2[0];
    assign serial_s = sync2[1];
    assign ext_s = sync2[2];
    assign strobe_s = sync2[3];
    assign sclk_s = sync2[4];

    logic sclk_rise, strobe_rise;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign strobe_rise = strobe_s & ~strobe_d;

    // ------------------------------------------------------------
    // Two-entry result buffer
    // ------------------------------------------------------------
    word_t mem [BUF_DEPTH];
    logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0] count, next_count;
    logic next_result_ready, next_word_ready;
    logic push, pop;
    word_t head;

    assign head = mem[rd_ptr];
    assign push = result_valid & result_ready;

    // Ready comes from a flop, so it is derived from the next occupancy.
    always_comb begin
        next_wr_ptr = wr_ptr ^ push;
        next_rd_ptr = rd_ptr ^ pop;
        next_count = count + {1'b0, push} - {1'b0, pop};
        next_result_ready = (next_count != 2'(BUF_DEPTH));
        next_word_ready = (next_count != 2'h0);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
            result_ready <= 1'b0;
            word_ready <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            result_ready <= next_result_ready;
            word_ready <= next_word_ready;
        end
        if (push) begin
            mem[wr_ptr] <= result_data;
        end
    end

    // ------------------------------------------------------------
    // Parallel bus, serial shifter and internal clock divider
    // ------------------------------------------------------------
    word_t shifter, next_shifter, next_data_out, next_oe_n;
    logic [BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
    logic [DIV_W-1:0] div, next_div;
    logic busy, next_busy, next_sclk_out, next_sclk_oe_n;
    logic master_run, div_wrap, shift_evt;

    assign master_run = busy & serial_s & ~ext_s;
    assign div_wrap = (div == DIV_W'(SCLK_HALF_CYC - 1));
    // Master shifts on the falling edge it makes; slave on the host's rising edge.
    assign shift_evt = busy & (ext_s ? sclk_rise : (div_wrap & sclk_out));

    // In parallel mode a word is popped per host read strobe; in serial
    // mode a word is popped whenever the shifter is idle.
    always_comb begin
        pop = (count != 2'h0) & (serial_s ? ~busy : strobe_rise);
        next_shifter = shifter;
        next_bit_cnt = bit_cnt;
        next_busy = busy;
        next_div = '0;
        next_sclk_out = 1'b0;
        next_data_out = data_out;
        if (pop && serial_s) begin
            next_shifter = apply_coding(head, coding_s);
            next_bit_cnt = LAST_BIT;
            next_busy = 1'b1;
        end else if (shift_evt) begin
            next_shifter = {shifter[MSB_BIT-1:0], 1'b0};
            next_bit_cnt = bit_cnt - 1'b1;
            next_busy = (bit_cnt != '0);
        end
        if (master_run) begin
            next_div = div_wrap ? '0 : div + 1'b1;
            next_sclk_out = div_wrap ? ~sclk_out : sclk_out;
        end
        if (pop && !serial_s) begin
            next_data_out = apply_coding(head, coding_s);
        end
        if (serial_s) begin
            next_data_out[SDOUT_BIT] = next_shifter[MSB_BIT];
        end
        // Pins 0..3 always drive; 4..7 turn into inputs in serial mode.
        next_oe_n = '0;
        if (serial_s) begin
            next_oe_n[SER_IN_HI:SCLK_SEL_BIT] = '1;
        end
        next_sclk_oe_n = ~(serial_s & ~ext_s);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shifter <= '0;
            bit_cnt <= '0;
            busy <= 1'b0;
            div <= '0;
            sclk_out <= 1'b0;
            sclk_oe_n <= 1'b1;
            data_out <= '0;
            data_oe_n <= '0;
        end else begin
            shifter <= next_shifter;
            bit_cnt <= next_bit_cnt;
            busy <= next_busy;
            div <= next_div;
            sclk_out <= next_sclk_out;
            sclk_oe_n <= next_sclk_oe_n;
            data_out <= next_data_out;
            data_oe_n <= next_oe_n;
        end
    end

    // ------------------------------------------------------------
    // Assertions and coverage
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    localparam int TOGGLE_MAX = 4;

    coding_msb_a: assert property (pop && !serial_s |=>
        data_out[MSB_BIT] == ($past(head[MSB_BIT]) ^ ~$past(coding_s)))
        else $error("Parallel word MSB does not follow coding select.");
    ser_load_a: assert property (pop && serial_s |=>
        shifter == apply_coding($past(head), $past(coding_s)) && bit_cnt == LAST_BIT)
        else $error("Serial shifter loaded with wrong word.");
    par_drive_a: assert property (!serial_s |=> data_oe_n == '0)
        else $error("Parallel mode left a data pin undriven.");
    ser_pins_a: assert property (serial_s |=> data_oe_n[SER_IN_HI:SCLK_SEL_BIT] == '1 &&
        data_out[SDOUT_BIT] == shifter[MSB_BIT])
        else $error("Serial mode pin roles wrong.");
    low_drive_a: assert property (data_oe_n[LOW_PINS-1:0] == '0)
        else $error("Low data pins not driven.");
    pin4_role_a: assert property (##1 data_oe_n[SCLK_SEL_BIT] == $past(serial_s))
        else $error("Pin 4 direction does not follow port type.");
    int_clk_a: assert property (master_run && $stable(master_run) |->
        ##[1:TOGGLE_MAX] (sclk_out != $past(sclk_out)) || !master_run)
        else $error("Internal serial clock does not toggle.");
    ext_shift_a: assert property (busy && ext_s && sclk_rise && !(pop && serial_s) && bit_cnt != '0 |=>
        bit_cnt == $past(bit_cnt) - 1'b1 && sclk_oe_n)
        else $error("External clock edge did not shift data.");

    par_read_c: cover property (strobe_rise && !serial_s && count != 2'h0);
    master_word_c: cover property (master_run && shift_evt && bit_cnt == '0);
    slave_word_c: cover property (busy && ext_s && shift_evt && bit_cnt == '0);
    buf_full_c: cover property (count == 2'(BUF_DEPTH) && result_valid);

endmodule // adc_output_port

`default_nettype wire

// file: test/host_model.sv
/*
 * Host model on the far side of the converter output port: strobes parallel
 * reads and captures serial words on the internal or an external clock.
 * Assumes the bench resolves the shared pins and calls these tasks in turn.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic ref_clk,
    input wire adc_port_pkg::word_t data_out,
    input wire logic sclk_pin,
    output logic read_strobe,
    output logic host_sclk
);
    import adc_port_pkg::*;

    // ------------------------------------------------------------
    // Transfers
    // ------------------------------------------------------------
    // Idle levels; the external clock stands low outside frames.
    initial begin
        read_strobe = 1'b0;
        host_sclk = 1'b0;
    end

    // The strobe stays high six cycles so the synchronised pop has landed.
    task automatic par_read(output word_t w);
        @(negedge ref_clk) read_strobe = 1'b1;
        repeat (6) @(negedge ref_clk);
        w = data_out;
        read_strobe = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask

    // Device clock: the data pin is taken on each rising edge seen.
    task automatic ser_int(output word_t w);
        logic last;
        int got;
        last = 1'b0;
        got = 0;
        for (int n = 0; n < 200 && got < 16; n++) begin
            @(negedge ref_clk);
            if (sclk_pin && !last) begin
                w = {w[14:0], data_out[SDOUT_BIT]};
                got++;
            end
            last = sclk_pin;
        end
    endtask

    // External clock of 320 ns. The device shows the MSB at load and moves on at
    // each rising edge, so a bit is taken at the end of the low phase.
    task automatic ser_ext(output word_t w);
        for (int i = 0; i < 16; i++) begin
            @(negedge ref_clk);
            w = {w[14:0], data_out[SDOUT_BIT]};
            host_sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            host_sclk = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
    endtask
endmodule // host_model

`default_nettype wire

// file: test/adc_output_port_test.sv
/*
 * Self-checking bench for the converter output port: reset, parallel reads
 * in both codings, serial words on the internal and the external clock.
 * Assumes the host model file and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_output_port_test;
    import adc_port_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    word_t result_data = '0;
    logic result_valid = 1'b0;
    logic output_coding_select = 1'b1;
    logic port_type_select = 1'b0;
    logic clk_sel = 1'b0;
    logic result_ready, word_ready, read_strobe, sclk_out, sclk_oe_n, host_sclk, sclk_pin;
    word_t data_in, data_out, data_oe_n, w;
    int err_count = 0;
    int checks = 0;

    // ------------------------------------------------------------
    // Clock, pins and instances
    // ------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;

    // A released pin takes the host's level; pins 5..7 are tied low by the host.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            data_in[i] = data_oe_n[i] ? (i == SCLK_SEL_BIT ? clk_sel : 1'b0) : data_out[i];
        end
    end
    assign sclk_pin = sclk_oe_n ? host_sclk : sclk_out;

    adc_output_port i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .result_data(result_data),
        .result_valid(result_valid), .result_ready(result_ready),
        .output_coding_select(output_coding_select), .port_type_select(port_type_select),
        .read_strobe(read_strobe), .word_ready(word_ready), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .sclk_in(sclk_pin), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n));
    host_model i_host (.ref_clk(ref_clk), .data_out(data_out), .sclk_pin(sclk_pin),
        .read_strobe(read_strobe), .host_sclk(host_sclk));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input word_t seen, input word_t exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the word until the buffer has room, then drops valid a cycle later.
    task automatic push(input word_t d);
        @(negedge ref_clk);
        result_data = d;
        result_valid = 1'b1;
        for (int n = 0; n < 20 && result_ready !== 1'b1; n++) @(negedge ref_clk);
        @(negedge ref_clk);
        result_valid = 1'b0;
    endtask

    task automatic stop_test;
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Fill the buffer, read the first word in straight binary and the second in two's complement, then read it empty.
    task automatic t_parallel;
        push(16'h8421);
        push(16'h7ffe);
        check({15'h0, result_ready}, 16'h0000);
        check(data_oe_n, 16'h0000);
        i_host.par_read(w);
        check(w, 16'h8421);
        output_coding_select = 1'b0;
        repeat (4) @(negedge ref_clk);
        i_host.par_read(w);
        check(w, 16'hfffe);
        check({15'h0, word_ready}, 16'h0000);
        i_host.par_read(w);
        check(w, 16'hfffe);
    endtask

    // Serial mode on the device's own clock, two's complement coding.
    task automatic t_ser_int;
        port_type_select = 1'b1;
        // Pin 4 is released only after the mode is seen, then its level needs two more flops.
        repeat (8) @(negedge ref_clk);
        check(data_oe_n, 16'h00f0);
        check({15'h0, sclk_oe_n}, 16'h0000);
        push(16'h1234);
        i_host.ser_int(w);
        check(w, 16'h9234);
        repeat (4) @(negedge ref_clk);
        check({15'h0, sclk_out}, 16'h0000);
    endtask

    // Serial mode on the host's clock, straight binary coding.
    task automatic t_ser_ext;
        clk_sel = 1'b1;
        output_coding_select = 1'b1;
        repeat (5) @(negedge ref_clk);
        check({15'h0, sclk_oe_n}, 16'h0001);
        check(data_oe_n, 16'h00f0);
        push(16'hc3a5);
        repeat (4) @(negedge ref_clk);
        i_host.ser_ext(w);
        check(w, 16'hc3a5);
    endtask

    // Main sequence: reset values first, then each mode in turn.
    initial begin
        repeat (8) @(negedge ref_clk);
        check({13'h0, word_ready, result_ready, sclk_oe_n}, 16'h0001);
        check(data_oe_n, 16'h0000);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_parallel();
        t_ser_int();
        t_ser_ext();
        stop_test();
    end

    // Cuts a hang short well beyond the few hundred cycles the run needs.
    initial begin
        repeat (6000) @(posedge ref_clk);
        err_count++;
        stop_test();
    end
endmodule // adc_output_port_test

`default_nettype wire
